// ==== hdl/sewt_target.v ====
`timescale 1ns/1ps
`include "sewt_defs.vh"
// Behaviour
// - Protect high blocks all array changes
// - Small variant: 128x32 pages, 12-bit address
// - Large variant: 256x32 pages, 13-bit address
// - Data edge with clock high is condition
// - Falling data, clock high starts transaction
// - Rising data, clock high stops; standby
// - Acknowledge each received byte on ninth
// - Standby at reset and after stop
// - Sample on rising, shift after falling
// - Check fixed four-bit type prefix
// - Compare three bits against chip straps
// - Address bit zero selects read/write
// - Ack match; mismatch returns to standby
// - Byte write: two address bytes, data
// - Self-timed write cycle ignores all inputs but reset
// - Page write up to 16 bytes (FIFO depth); later bytes acked, dropped
// - Writes increment only low five address bits; reads the whole address
// - Acknowledge polling only after write done
// - Address counter holds last plus one
// - Random read: dummy write then restart
// - Read continues while controller acknowledges
module sewt_target #(
  parameter ADDR_BITS = `SEWT_ADDR_BITS_SMALL,
  parameter TWR_CYCLES = `SEWT_TWR_CYCLES
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  input wire [2:0] chip_select_straps_i,
  input wire write_protect_i,
  output wire busy_o,
  output wire standby_o
);
  localparam DEPTH = 1 << ADDR_BITS;
  localparam FW = ADDR_BITS + 8;
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 7'b000_0001;
  localparam ST_DEV = 7'b000_0010;
  localparam ST_AHI = 7'b000_0100;
  localparam ST_ALO = 7'b000_1000;
  localparam ST_WDAT = 7'b001_0000;
  localparam ST_RDAT = 7'b010_0000;
  localparam ST_RACK = 7'b100_0000;

  function [ADDR_BITS-1:0] page_inc;
    input [ADDR_BITS-1:0] a;
    begin
      page_inc = {a[ADDR_BITS-1:`SEWT_PAGE_BITS],
        a[`SEWT_PAGE_BITS-1:0] + 1'b1};
    end
  endfunction

  reg [7:0] mem_ff [0:DEPTH-1];
  reg [6:0] st_ff;
  reg [3:0] bit_ff;
  reg [7:0] sh_ff;
  reg [ADDR_BITS-1:0] addr_ff;
  reg [ADDR_BITS-1:0] wptr_ff;
  reg [7:0] ahi_ff;
  reg scl_d_ff;
  reg sda_d_ff;
  reg drive_low_ff;
  reg ack_phase_ff;
  reg got_write_ff;
  reg wr_busy_ff;
  reg [31:0] twr_ff;
  reg [7:0] out_ff;
  reg master_nak_ff;
  wire scl_s;
  wire sda_s;
  wire wp_s;
  wire [2:0] cs_s;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire [15:0] addr_ld;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [FW-1:0] fifo_out;
  reg fifo_push;
  reg fifo_pop;
  reg [FW-1:0] fifo_in;

  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------
  sewt_sync #(.WIDTH(6)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i({scl_i, sda_i, write_protect_i, chip_select_straps_i}),
    .sync_o({scl_s, sda_s, wp_s, cs_s})
  );

  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d_ff;
  assign scl_fall = !scl_s && scl_d_ff;
  // Data edges under a high clock are conditions, not bits
  assign start_cond = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  assign stop_cond = scl_s && scl_d_ff && !sda_d_ff && sda_s;
  // Upper address byte bits above the width are dropped
  assign addr_ld = {ahi_ff, sh_ff};

  // ----------------------------------------
  // Write FIFO: page bytes staged until stop
  // ----------------------------------------
  sewt_fifo #(.WIDTH(FW), .DEPTH(`SEWT_FIFO_DEPTH), .AW(4)) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .clear_i(start_cond && !wr_busy_ff),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out)
  );

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  always @(posedge core_clk_i)
  begin
    fifo_push <= 1'b0;
    fifo_in <= fifo_in;
    if (rst_i)
    begin
      st_ff <= ST_IDLE;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      addr_ff <= {ADDR_BITS{1'b0}};
      ahi_ff <= 8'h00;
      drive_low_ff <= 1'b0;
      ack_phase_ff <= 1'b0;
      got_write_ff <= 1'b0;
      out_ff <= 8'h00;
      master_nak_ff <= 1'b0;
      fifo_in <= {FW{1'b0}};
    end
    else if (wr_busy_ff)
    begin
      // Inputs ignored while programming
      st_ff <= ST_IDLE;
      drive_low_ff <= 1'b0;
      ack_phase_ff <= 1'b0;
      got_write_ff <= 1'b0;
    end
    else if (start_cond)
    begin
      st_ff <= ST_DEV;
      bit_ff <= 4'h0;
      drive_low_ff <= 1'b0;
      ack_phase_ff <= 1'b0;
      got_write_ff <= 1'b0;
    end
    else if (stop_cond)
    begin
      st_ff <= ST_IDLE;
      drive_low_ff <= 1'b0;
      ack_phase_ff <= 1'b0;
    end
    else if (st_ff != ST_IDLE)
    begin
      if (scl_rise)
      begin
        if (ack_phase_ff)
        begin
          if (st_ff == ST_RDAT)
            master_nak_ff <= sda_s;
        end
        else if (st_ff != ST_RDAT)
        begin
          sh_ff <= {sh_ff[6:0], sda_s};
          bit_ff <= bit_ff + 1'b1;
        end
      end
      if (scl_fall)
      begin
        if (ack_phase_ff)
        begin
          ack_phase_ff <= 1'b0;
          bit_ff <= 4'h0;
          drive_low_ff <= 1'b0;
          if (st_ff == ST_RDAT)
          begin
            if (master_nak_ff)
              st_ff <= ST_RACK;
            else
            begin
              out_ff <= mem_ff[addr_ff];
              addr_ff <= addr_ff + 1'b1;
              drive_low_ff <= !mem_ff[addr_ff][7];
            end
          end
          else if (st_ff == ST_RACK)
            st_ff <= ST_RACK;
        end
        else if (st_ff == ST_RDAT)
        begin
          if (bit_ff == 4'd7)
          begin
            ack_phase_ff <= 1'b1;
            drive_low_ff <= 1'b0;
          end
          else
          begin
            bit_ff <= bit_ff + 1'b1;
            drive_low_ff <= !out_ff[3'd6 - bit_ff[2:0]];
          end
        end
        else if (bit_ff == 4'd8)
        begin
          ack_phase_ff <= 1'b1;
          case (st_ff)
            ST_DEV:
            begin
              if (sh_ff[7:4] == `SEWT_TYPE_PREFIX &&
                  sh_ff[3:1] == cs_s)
              begin
                drive_low_ff <= 1'b1;
                if (sh_ff[0])
                begin
                  st_ff <= ST_RDAT;
                  master_nak_ff <= 1'b0;
                end
                else
                  st_ff <= ST_AHI;
              end
              else
                st_ff <= ST_IDLE;
            end
            ST_AHI:
            begin
              ahi_ff <= sh_ff;
              drive_low_ff <= 1'b1;
              st_ff <= ST_ALO;
            end
            ST_ALO:
            begin
              addr_ff <= addr_ld[ADDR_BITS-1:0];
              drive_low_ff <= 1'b1;
              st_ff <= ST_WDAT;
            end
            ST_WDAT:
            begin
              drive_low_ff <= 1'b1;
              if (!wp_s && fifo_in_ready)
              begin
                fifo_push <= 1'b1;
                fifo_in <= {addr_ff, sh_ff};
                got_write_ff <= 1'b1;
              end
              addr_ff <= page_inc(addr_ff);
            end
            default:
            begin
              st_ff <= ST_IDLE;
            end
          endcase
        end
      end
      // Read data first bit goes out after the ack clock
      if (scl_fall && ack_phase_ff && st_ff == ST_DEV)
        drive_low_ff <= 1'b0;
    end
  end

  // First read bit must appear after falling edge of ack
  reg rd_first_ff;
  always @(posedge core_clk_i)
  begin
    if (rst_i)
      rd_first_ff <= 1'b0;
    else
      rd_first_ff <= scl_fall && ack_phase_ff && st_ff == ST_RDAT &&
        !master_nak_ff;
  end

  // ----------------------------------------
  // Self-timed programming cycle
  // ----------------------------------------
  always @(posedge core_clk_i)
  begin
    fifo_pop <= 1'b0;
    if (rst_i)
    begin
      wr_busy_ff <= 1'b0;
      twr_ff <= 32'h0000_0000;
    end
    else if (!wr_busy_ff)
    begin
      if (stop_cond && got_write_ff && st_ff == ST_WDAT &&
          !wp_s)
      begin
        wr_busy_ff <= 1'b1;
        twr_ff <= TWR_CYCLES;
      end
    end
    else
    begin
      if (fifo_out_valid && !fifo_pop)
      begin
        mem_ff[fifo_out[FW-1:8]] <= fifo_out[7:0];
        fifo_pop <= 1'b1;
      end
      if (twr_ff <= 32'h0000_0001)
        wr_busy_ff <= 1'b0;
      else
        twr_ff <= twr_ff - 1'b1;
    end
  end

  // Open drain: pull low only
  assign sda_o = 1'b0;
  assign sda_oe_o = drive_low_ff;
  assign busy_o = wr_busy_ff;
  assign standby_o = (st_ff == ST_IDLE) && !wr_busy_ff;
endmodule

// ==== inc/sewt_defs.vh ====
`ifndef SEWT_DEFS_VH
`define SEWT_DEFS_VH
// ----------------------------------------
// Device address word
// ----------------------------------------
`define SEWT_TYPE_PREFIX 4'b1010
// ----------------------------------------
// Array organisation
// ----------------------------------------
`define SEWT_PAGE_BITS 5
`define SEWT_ADDR_BITS_SMALL 12
`define SEWT_ADDR_BITS_LARGE 13
// ----------------------------------------
// Timing
// ----------------------------------------
`define SEWT_CLK_MHZ 100
`define SEWT_TWR_US 5000
`define SEWT_TWR_CYCLES (`SEWT_TWR_US * `SEWT_CLK_MHZ)
`define SEWT_FIFO_DEPTH 16
`endif

// ==== hdl/sewt_sync.v ====
`timescale 1ns/1ps
// ----------------------------------------
// Two-stage synchroniser
// ----------------------------------------
module sewt_sync #(
  parameter WIDTH = 1
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      meta_ff <= {WIDTH{1'b1}};
      sync_ff <= {WIDTH{1'b1}};
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end
  assign sync_o = sync_ff;
endmodule

// ==== hdl/sewt_fifo.v ====
`timescale 1ns/1ps
// ----------------------------------------
// Write data FIFO
// ----------------------------------------
module sewt_fifo #(
  parameter WIDTH = 21,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire clear_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ff;
  reg [AW-1:0] rd_ff;
  reg [AW:0] cnt_ff;
  wire push;
  wire pop;
  assign in_ready_o = (cnt_ff != DEPTH);
  assign out_valid_o = (cnt_ff != 0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_ff[rd_ff];
  always @(posedge core_clk_i)
  begin
    if (push)
      mem_ff[wr_ff] <= in_data_i;
  end
  always @(posedge core_clk_i)
  begin
    if (rst_i || clear_i)
    begin
      wr_ff <= {AW{1'b0}};
      rd_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ff <= wr_ff + 1'b1;
      if (pop)
        rd_ff <= rd_ff + 1'b1;
      if (push && !pop)
        cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule

// ==== bench/sewt_ctl_model.sv ====
`timescale 1ns/1ps
module sewt_ctl_model (
  input wire core_clk_i,
  input wire sda_i,
  output logic scl_o,
  output logic sda_o
);
  // --------------------------------
  // Bus controller phases
  // --------------------------------
  // Clock idles high between frames; data released to the pull-up
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic start;
    sda_o = 1'b1;
    wt(8);
    scl_o = 1'b1;
    wt(8);
    sda_o = 1'b0;
    wt(8);
    scl_o = 1'b0;
  endtask

  task automatic stop;
    sda_o = 1'b0;
    wt(8);
    scl_o = 1'b1;
    wt(8);
    sda_o = 1'b1;
    wt(8);
  endtask

  task automatic bit_x(input logic b, output logic r);
    sda_o = b;
    wt(8);
    scl_o = 1'b1;
    wt(4);
    r = sda_i;
    wt(4);
    scl_o = 1'b0;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask

  // Last byte answered with a high bit to end a read
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(!more, r);
  endtask
endmodule

// ==== bench/sewt_target_assertions.sv ====
`timescale 1ns/1ps
module sewt_target_assertions #(
  parameter TWR_CYCLES = 500000
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire write_protect_i,
  input wire busy_o,
  input wire standby_o
);
  // --------------------------------
  // Write cycle length counter
  // --------------------------------
  logic [31:0] busy_cnt_ff;
  always_ff @(posedge core_clk_i)
    if (rst_i || !busy_o)
      busy_cnt_ff <= '0;
    else
      busy_cnt_ff <= busy_cnt_ff + 32'd1;

  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  a_drive_low:
    assert property (sda_oe_o |-> !sda_o)
    else $error("data pin driven high");
  a_oe_scl_low:
    assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
    else $error("data drive changed with clock high");
  a_quiet_busy:
    assert property (busy_o |-> !sda_oe_o)
    else $error("data driven during write cycle");
  a_busy_standby:
    assert property (busy_o |-> !standby_o)
    else $error("standby during write cycle");
  a_reset_standby:
    assert property ($fell(rst_i) |-> standby_o && !busy_o && !sda_oe_o)
    else $error("not idle after reset");
  a_twr_max:
    assert property (busy_o |-> busy_cnt_ff <= TWR_CYCLES)
    else $error("write cycle too long");
  a_twr_min:
    assert property ($fell(busy_o) |-> busy_cnt_ff >= TWR_CYCLES - 1)
    else $error("write cycle too short");
  a_wp_no_prog:
    assert property ($rose(busy_o) |-> !write_protect_i)
    else $error("write cycle while protected");
  a_stop_idle:
    assert property (scl_i && $past(scl_i) && $rose(sda_i)
      |-> ##[1:40] (standby_o || busy_o))
    else $error("no standby after stop");
endmodule

bind sewt_target sewt_target_assertions #(.TWR_CYCLES(TWR_CYCLES)) u_chk (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .write_protect_i(write_protect_i),
  .busy_o(busy_o),
  .standby_o(standby_o)
);

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`include "sewt_defs.vh"
module tb;
  localparam logic [2:0] CS = 3'h5;
  logic core_clk, rst, wp, scl, sda_c, sda_d, sda_oe, busy, stby;
  wire sda_w = sda_c & (sda_oe ? sda_d : 1'b1);
  int num_errors = 0;
  int num_checks = 0;

  // --------------------------------
  // Harness
  // --------------------------------
  sewt_target #(.ADDR_BITS(12), .TWR_CYCLES(200)) u_sewt_target (
    .core_clk_i(core_clk),
    .rst_i(rst),
    .scl_i(scl),
    .sda_i(sda_w),
    .sda_o(sda_d),
    .sda_oe_o(sda_oe),
    .chip_select_straps_i(CS),
    .write_protect_i(wp),
    .busy_o(busy),
    .standby_o(stby)
  );
  sewt_ctl_model u_ctl (
    .core_clk_i(core_clk),
    .sda_i(sda_w),
    .scl_o(scl),
    .sda_o(sda_c)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk1(input logic g, input logic e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t flag %b exp %b", $time, g, e);
    end
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t byte %h exp %h", $time, g, e);
    end
  endtask

  task automatic dev(input logic [3:0] p, input logic [2:0] c,
    input logic rd);
    logic a;
    u_ctl.start();
    u_ctl.wr_byte({p, c, rd}, a);
    chk1(a, 1'b1);
  endtask

  task automatic set_addr(input logic [15:0] adr);
    logic a;
    dev(`SEWT_TYPE_PREFIX, CS, 1'b0);
    u_ctl.wr_byte(adr[15:8], a);
    chk1(a, 1'b1);
    u_ctl.wr_byte(adr[7:0], a);
    chk1(a, 1'b1);
  endtask

  task automatic rd1(input logic [15:0] adr, input logic [7:0] e);
    logic [7:0] d;
    set_addr(adr);
    dev(`SEWT_TYPE_PREFIX, CS, 1'b1);
    u_ctl.rd_byte(1'b0, d);
    chk8(d, e);
    u_ctl.stop();
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 400)
    begin
      @(negedge core_clk);
      n++;
    end
    chk1(busy, 1'b0);
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_write;
    logic a;
    set_addr(16'hf123);
    u_ctl.wr_byte(8'h5a, a);
    chk1(a, 1'b1);
    u_ctl.stop();
    chk1(busy, 1'b1);
    u_ctl.start();
    u_ctl.wr_byte({`SEWT_TYPE_PREFIX, CS, 1'b0}, a);
    chk1(a, 1'b0);
    u_ctl.stop();
    wait_idle();
    chk1(stby, 1'b1);
    rd1(16'h0123, 8'h5a);
    chk1(stby, 1'b1);
    $display("t_write done");
  endtask

  task automatic t_mismatch;
    logic a;
    for (int i = 0; i < 2; i++)
    begin
      u_ctl.start();
      u_ctl.wr_byte({i ? 4'ha : 4'hb, i ? 3'h4 : CS, 1'b0}, a);
      chk1(a, 1'b0);
      u_ctl.stop();
      chk1(stby, 1'b1);
    end
    $display("t_mismatch done");
  endtask

  task automatic t_page;
    logic a;
    logic [7:0] d;
    set_addr(16'h005e);
    for (int i = 0; i < 4; i++)
    begin
      u_ctl.wr_byte(8'h10 + 8'(i), a);
      chk1(a, 1'b1);
    end
    u_ctl.stop();
    wait_idle();
    set_addr(16'h0040);
    dev(`SEWT_TYPE_PREFIX, CS, 1'b1);
    u_ctl.rd_byte(1'b1, d);
    chk8(d, 8'h12);
    u_ctl.rd_byte(1'b0, d);
    chk8(d, 8'h13);
    u_ctl.stop();
    rd1(16'h005e, 8'h10);
    dev(`SEWT_TYPE_PREFIX, CS, 1'b1);
    u_ctl.rd_byte(1'b0, d);
    chk8(d, 8'h11);
    u_ctl.stop();
    $display("t_page done");
  endtask

  task automatic t_protect;
    logic a;
    wp = 1'b1;
    set_addr(16'h0123);
    u_ctl.wr_byte(8'ha5, a);
    chk1(a, 1'b1);
    u_ctl.stop();
    chk1(busy, 1'b0);
    wp = 1'b0;
    rd1(16'h1123, 8'h5a);
    $display("t_protect done");
  endtask

  initial
  begin
    rst = 1'b1;
    wp = 1'b0;
    repeat (5) @(negedge core_clk);
    chk1(stby, 1'b1);
    chk1(sda_oe, 1'b0);
    rst = 1'b0;
    repeat (6) @(negedge core_clk);
    t_write();
    t_mismatch();
    t_page();
    t_protect();
    final_report();
  end

  // Whole run needs about 6700 cycles
  initial
  begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
endmodule
